// File: hdl/wdc_pkg.sv
// wdc_pkg: shared constants and types for the watchdog block
// assumes one system clock of 100 MHz and a slow free-running watchdog oscillator pin
package wdc_pkg;

   // ------------------------------------------------------------
   // register bus
   // ------------------------------------------------------------
   localparam int WDC_ADDR_W = 8;                     // register address width
   localparam int WDC_DATA_W = 8;                     // register data width
   localparam logic [WDC_ADDR_W-1:0] WDC_CTRL_OFFSET = 8'h00;  // watchdog_control
   localparam logic [WDC_ADDR_W-1:0] WDC_STAT_OFFSET = 8'h01;  // state readback
   localparam logic [WDC_DATA_W-1:0] WDC_CTRL_RESET = 8'h00;   // control after reset
   localparam logic [WDC_DATA_W-1:0] WDC_READ_ZERO = 8'h00;    // unmapped and reserved

   // ------------------------------------------------------------
   // watchdog_control field layout
   // ------------------------------------------------------------
   localparam int WDC_UNLOCK_BIT = 4;                 // turn_off_unlock
   localparam int WDC_ON_BIT = 3;                     // watchdog_on
   localparam int WDC_SEL_LSB = 0;                    // period_select_bit0
   localparam int WDC_SEL_W = 3;                      // period select width

   // ------------------------------------------------------------
   // status readback field layout
   // ------------------------------------------------------------
   localparam int WDC_STAT_RUN_BIT = 0;               // counter is running
   localparam int WDC_STAT_FIRED_BIT = 1;             // timeout reset requested
   localparam int WDC_STAT_UNLOCK_BIT = 2;            // unlock window open

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int WDC_UNLOCK_CYCLES = 4;              // turn_off_unlock lifetime, cpu cycles
   localparam int WDC_OSC_FREQ_KHZ = 1000;            // nominal watchdog oscillator rate
   localparam int WDC_PERIOD_BASE = 16384;            // shortest period, oscillator cycles
   localparam int WDC_CNT_W = 21;                     // holds 2048K oscillator cycles

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef logic [WDC_SEL_W-1:0] wdc_sel_type;

   typedef struct packed {
      logic [WDC_ADDR_W-1:0] addr;                    // register address
      logic [WDC_DATA_W-1:0] wdata;                   // write data
      logic wr;                                       // one-cycle write strobe
      logic rd;                                       // one-cycle read strobe
   } wdc_bus_req_type;

   typedef enum logic [1:0] {
      WDC_ST_IDLE,                                    // watchdog off, count held
      WDC_ST_RUN,                                     // counting oscillator edges
      WDC_ST_FIRED                                    // reset request raised
   } wdc_state_type;

endpackage

// File: hdl/wdc_edge_sync.sv
// wdc_edge_sync: brings the watchdog oscillator pin into the system clock domain
// assumes the oscillator runs much slower than clk, so every edge is seen
`timescale 1ns/100ps
`default_nettype none
module wdc_edge_sync (
   input wire logic clk,                              // system clock
   input wire logic rst_n,                            // async reset, active low
   input wire logic async_in,                         // oscillator pin
   output logic rise_pulse                            // one cycle per rising edge
);
   // ------------------------------------------------------------
   // synchroniser and edge detector
   // ------------------------------------------------------------
   logic meta_r, meta_nxt;                            // first stage, read only by sync_r
   logic sync_r, sync_nxt;                            // second stage
   logic prev_r, prev_nxt;                            // delayed copy for edges
   logic rise_r, rise_nxt;                            // registered edge pulse

   // next values: shift chain, edge taken only from settled stages
   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
      prev_nxt = sync_r;
      rise_nxt = sync_r & ~prev_r;
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
         rise_r <= 1'b0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         prev_r <= prev_nxt;
         rise_r <= rise_nxt;
      end
   end

   assign rise_pulse = rise_r;
endmodule
`default_nettype wire

// File: hdl/wdc_watchdog.sv
// wdc_watchdog: watchdog timer with guarded turn-off and selectable period
// assumes a cpu-side register port on clk and a refresh pulse from the core
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// R1 - count edges of separate watchdog oscillator
// R2 - refresh instruction clears the watchdog count
// R3 - expiry while enabled requests system reset
// R4 - control bits seven to five read zero
// R5 - unlock bit self-clears four cycles later
// R6 - clearing enable needs unlock bit set
// R7 - software writes enable and unlock first
// R8 - period select chooses 16K to 2048K
// R9 - software refreshes before enabling
// R10 - software refreshes before changing period
// R11 - cross oscillator safely, register reset request
module wdc_watchdog
   import wdc_pkg::*;
#(
   parameter int PERIOD_BASE = wdc_pkg::WDC_PERIOD_BASE,   // shortest period, osc cycles
   parameter int UNLOCK_CYCLES = wdc_pkg::WDC_UNLOCK_CYCLES // unlock lifetime
) (
   input wire logic clk,                              // system clock, 100 MHz
   input wire logic rst_n,                            // async reset, active low
   input wire logic wdt_osc,                          // watchdog oscillator pin
   input wire logic refresh_instruction,              // one-cycle refresh from core
   input wire wdc_pkg::wdc_bus_req_type bus_req,      // register request
   output logic [wdc_pkg::WDC_DATA_W-1:0] rdata,      // read data, cycle after rd
   output logic sys_reset_req                         // timeout reset request, level
);
   import wdc_pkg::*;

   // ------------------------------------------------------------
   // local declarations
   // ------------------------------------------------------------
   localparam int OSC_PERIOD_NS = 1000000 / WDC_OSC_FREQ_KHZ;  // nominal osc period
   localparam logic [2:0] UNLOCK_LOAD = 3'(UNLOCK_CYCLES);     // countdown load value
   localparam logic [2:0] UNLOCK_LAST = 3'h1;                  // final unlocked cycle
   localparam logic [2:0] UNLOCK_DONE = 3'h0;                  // window closed

   logic osc_rise;                                    // one pulse per osc edge
   logic ctrl_wr;                                     // write hits control
   logic [WDC_DATA_W-1:0] ctrl_view;                  // control as software sees it
   logic [WDC_DATA_W-1:0] stat_view;                  // status as software sees it
   logic [WDC_CNT_W-1:0] limit;                       // last count of selected period

   logic on_r, on_nxt;                                // watchdog_on
   logic unlock_r, unlock_nxt;                        // turn_off_unlock
   logic [2:0] unlock_cnt_r, unlock_cnt_nxt;          // unlock lifetime countdown
   wdc_sel_type sel_r, sel_nxt;                       // period select
   logic [WDC_CNT_W-1:0] cnt_r, cnt_nxt;              // oscillator edge count
   wdc_state_type state_r, state_nxt;                 // watchdog state
   logic fire_r, fire_nxt;                            // reset request flop
   logic [WDC_DATA_W-1:0] rdata_r, rdata_nxt;         // read data flop

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // last count value for a period select code: base shifted by the code, less one
   function automatic logic [WDC_CNT_W-1:0] period_last(input wdc_sel_type sel);
      logic [WDC_CNT_W:0] span;
      span = (WDC_CNT_W+1)'(PERIOD_BASE) << sel;
      period_last = WDC_CNT_W'(span - (WDC_CNT_W+1)'(1));
   endfunction

   // address decode, used for reads and writes
   function automatic logic hit(input logic [WDC_ADDR_W-1:0] addr,
                                input logic [WDC_ADDR_W-1:0] offset);
      hit = (addr == offset);
   endfunction

   // ------------------------------------------------------------
   // oscillator crossing
   // ------------------------------------------------------------
   // the oscillator is a pin here, so it is sampled rather than used as a clock;
   // this limits the oscillator to well below half the system clock
   wdc_edge_sync u_osc_sync (
      .clk(clk),
      .rst_n(rst_n),
      .async_in(wdt_osc),
      .rise_pulse(osc_rise)
   ); // R1 R11

   // ------------------------------------------------------------
   // control register
   // ------------------------------------------------------------
   assign ctrl_wr = bus_req.wr & hit(bus_req.addr, WDC_CTRL_OFFSET);

   // next values of enable, unlock and period select
   always_comb begin
      on_nxt = on_r;
      unlock_nxt = unlock_r;
      unlock_cnt_nxt = unlock_cnt_r;
      sel_nxt = sel_r;
      // the unlock window closes by itself; a new write below with the unlock bit set reloads it, one without it closes it
      if (unlock_cnt_r != UNLOCK_DONE) begin
         unlock_cnt_nxt = unlock_cnt_r - 3'h1;
         if (unlock_cnt_r == UNLOCK_LAST) begin
            unlock_nxt = 1'b0; // R5
         end
      end
      if (ctrl_wr) begin
         sel_nxt = bus_req.wdata[WDC_SEL_LSB +: WDC_SEL_W]; // R8
         if (bus_req.wdata[WDC_UNLOCK_BIT]) begin
            // a fresh set wins over the self clear in the same cycle
            unlock_nxt = 1'b1;
            unlock_cnt_nxt = UNLOCK_LOAD; // R5
         end else begin
            unlock_nxt = 1'b0;
            unlock_cnt_nxt = UNLOCK_DONE;
         end
         if (bus_req.wdata[WDC_ON_BIT]) begin
            on_nxt = 1'b1; // R6
         end else if (unlock_r) begin
            // clearing only lands while the earlier unlock write is live
            on_nxt = 1'b0; // R6 R7
         end
      end
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_r <= WDC_CTRL_RESET[WDC_ON_BIT];
         unlock_r <= WDC_CTRL_RESET[WDC_UNLOCK_BIT];
         unlock_cnt_r <= UNLOCK_DONE;
         sel_r <= WDC_CTRL_RESET[WDC_SEL_LSB +: WDC_SEL_W];
      end else begin
         on_r <= on_nxt;
         unlock_r <= unlock_nxt;
         unlock_cnt_r <= unlock_cnt_nxt;
         sel_r <= sel_nxt;
      end
   end

   // ------------------------------------------------------------
   // counter and timeout
   // ------------------------------------------------------------
   assign limit = period_last(sel_r); // R8

   // next count and state; a held count is not cleared on enable, so software
   // refreshes first, and refreshes before a period change
   always_comb begin
      cnt_nxt = cnt_r;
      state_nxt = state_r;
      fire_nxt = fire_r;
      case (state_r)
         WDC_ST_IDLE: begin
            if (refresh_instruction) begin
               cnt_nxt = '0; // R2 R9
            end
            if (on_r) begin
               state_nxt = WDC_ST_RUN;
            end
         end
         WDC_ST_RUN: begin
            if (!on_r) begin
               state_nxt = WDC_ST_IDLE;
               if (refresh_instruction) begin
                  cnt_nxt = '0; // R2
               end
            end else if (refresh_instruction) begin
               // refresh beats a coinciding oscillator edge
               cnt_nxt = '0; // R2 R10
            end else if (osc_rise) begin
               if (cnt_r >= limit) begin
                  state_nxt = WDC_ST_FIRED;
                  fire_nxt = 1'b1; // R3
               end else begin
                  cnt_nxt = cnt_r + WDC_CNT_W'(1); // R1
               end
            end
         end
         WDC_ST_FIRED: begin
            // held until the system reset comes back round to rst_n
            fire_nxt = 1'b1; // R3 R11
         end
         default: begin
            state_nxt = WDC_ST_IDLE;
            fire_nxt = 1'b0;
         end
      endcase
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         state_r <= WDC_ST_IDLE;
         fire_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         state_r <= state_nxt;
         fire_r <= fire_nxt;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   // reserved control bits are built as zero, not stored
   always_comb begin
      ctrl_view = WDC_READ_ZERO; // R4
      ctrl_view[WDC_UNLOCK_BIT] = unlock_r;
      ctrl_view[WDC_ON_BIT] = on_r;
      ctrl_view[WDC_SEL_LSB +: WDC_SEL_W] = sel_r;
      stat_view = WDC_READ_ZERO;
      stat_view[WDC_STAT_RUN_BIT] = (state_r == WDC_ST_RUN);
      stat_view[WDC_STAT_FIRED_BIT] = fire_r;
      stat_view[WDC_STAT_UNLOCK_BIT] = unlock_r;
   end

   // read data stand only in the cycle after the strobe
   always_comb begin
      rdata_nxt = WDC_READ_ZERO;
      if (bus_req.rd) begin
         if (hit(bus_req.addr, WDC_CTRL_OFFSET)) begin
            rdata_nxt = ctrl_view; // R4
         end else if (hit(bus_req.addr, WDC_STAT_OFFSET)) begin
            rdata_nxt = stat_view;
         end else begin
            rdata_nxt = WDC_READ_ZERO;
         end
      end
   end

   // registers only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_r <= WDC_READ_ZERO;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign rdata = rdata_r;
   assign sys_reset_req = fire_r; // R11
endmodule
`default_nettype wire

// File: verification/wdc_watchdog_chk.sv
// wdc_watchdog_chk: port-level assertions for the watchdog block
// assumes it is bound to wdc_watchdog and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module wdc_watchdog_chk
   import wdc_pkg::*;
#(
   parameter int PERIOD_BASE = WDC_PERIOD_BASE,       // shortest period, osc cycles
   parameter int UNLOCK_CYCLES = WDC_UNLOCK_CYCLES    // unlock lifetime
) (
   input wire logic clk,                              // system clock
   input wire logic rst_n,                            // async reset, active low
   input wire logic wdt_osc,                          // oscillator pin
   input wire logic refresh_instruction,              // refresh pulse
   input wire wdc_pkg::wdc_bus_req_type bus_req,      // register request
   input wire logic [wdc_pkg::WDC_DATA_W-1:0] rdata,  // read data
   input wire logic sys_reset_req                     // reset request
);
   import wdc_pkg::*;
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   logic ctrl_wr; // write to watchdog_control
   logic ctrl_rd; // read of watchdog_control
   assign ctrl_wr = bus_req.wr && (bus_req.addr == WDC_CTRL_OFFSET);
   assign ctrl_rd = bus_req.rd && (bus_req.addr == WDC_CTRL_OFFSET);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   // read data must not linger past its one cycle
   property p_rd_idle; !bus_req.rd |=> rdata == WDC_READ_ZERO; endproperty
   property p_reserved; ctrl_rd |=> rdata[7:5] == 3'b000; endproperty
   property p_sticky; sys_reset_req |=> sys_reset_req; endproperty
   // a fresh count cannot expire two cycles later
   property p_refresh; refresh_instruction |-> ##2 !$rose(sys_reset_req); endproperty
   property p_unlock_open;
      ctrl_wr && bus_req.wdata[4] ##1 !bus_req.wr [*3] ##1 ctrl_rd |=> rdata[4];
   endproperty
   property p_unlock_shut;
      ctrl_wr && bus_req.wdata[4] ##1 !bus_req.wr [*4] ##1 ctrl_rd |=> !rdata[4];
   endproperty
   // clearing the enable without the unlock bit is ignored
   property p_guard;
      ctrl_wr && bus_req.wdata[4:3] == 2'b01 ##2 ctrl_wr && bus_req.wdata[4:3] == 2'b00
         ##2 ctrl_rd |=> rdata[3];
   endproperty
   property p_turn_off;
      ctrl_wr && bus_req.wdata[4:3] == 2'b11 ##2 ctrl_wr && !bus_req.wdata[3]
         ##2 ctrl_rd |=> !rdata[3];
   endproperty
   // no oscillator edges means no expiry
   property p_osc; $stable(wdt_osc) [*8] |-> !$rose(sys_reset_req); endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
   a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
   a_sticky: assert property (p_sticky) else $error("reset request dropped");
   a_refresh: assert property (p_refresh) else $error("expiry right after refresh");
   a_unlock_open: assert property (p_unlock_open) else $error("unlock closed early");
   a_unlock_shut: assert property (p_unlock_shut) else $error("unlock stayed open");
   a_guard: assert property (p_guard) else $error("enable cleared without unlock");
   a_turn_off: assert property (p_turn_off) else $error("turn-off sequence failed");
   a_osc: assert property (p_osc) else $error("expiry without oscillator edge");
   c_fire: cover property ($rose(sys_reset_req));
   c_refresh: cover property (refresh_instruction);
   c_turn_off: cover property (ctrl_wr && bus_req.wdata[4:3] == 2'b11 ##2 ctrl_wr);
endmodule
bind wdc_watchdog wdc_watchdog_chk #(.PERIOD_BASE(PERIOD_BASE), .UNLOCK_CYCLES(UNLOCK_CYCLES))
   u_chk (.clk(clk), .rst_n(rst_n), .wdt_osc(wdt_osc), .refresh_instruction(refresh_instruction),
   .bus_req(bus_req), .rdata(rdata), .sys_reset_req(sys_reset_req));
`default_nettype wire

// File: verification/watchdog_timer_with_safe_disable_bench.sv
// watchdog_timer_with_safe_disable_bench: directed tests of wdc_watchdog
// assumes a shortened period base; the bench drives the oscillator pin itself
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_with_safe_disable_bench;
   import wdc_pkg::*;
   localparam int BASE = 4; // shortened shortest period keeps runs brief
   logic clk, rst_n, wdt_osc, refresh_instruction, sys_reset_req; // design pins
   wdc_bus_req_type req; // register request
   logic [WDC_DATA_W-1:0] rdata, got; // read data and last read
   int errors, checked, cycles; // counters
   wdc_watchdog #(.PERIOD_BASE(BASE), .UNLOCK_CYCLES(WDC_UNLOCK_CYCLES)) DUT (.clk(clk),
      .rst_n(rst_n), .wdt_osc(wdt_osc), .refresh_instruction(refresh_instruction),
      .bus_req(req), .rdata(rdata), .sys_reset_req(sys_reset_req));
   // ------------------------------------------------------------
   // clock, timeout and shared tasks
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // a hang is cut short well beyond the expected run length
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 30000) begin
         errors = errors + 1;
         conclude();
      end
   end
   task conclude;
      $display("errors=%0d checked=%0d", errors, checked);
      if (errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task check(input logic [7:0] g, input logic [7:0] e, input string m);
      checked = checked + 1;
      if (g !== e) begin
         errors = errors + 1;
         $display("ERROR %0t %s got %h expected %h", $time, m, g, e);
      end
   endtask
   task do_reset;
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] a);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 got = rdata;
   endtask
   task refresh;
      @(posedge clk);
      refresh_instruction <= 1'b1;
      @(posedge clk);
      refresh_instruction <= 1'b0;
   endtask
   // n rising edges, eight system cycles per oscillator period
   task osc(input int n);
      repeat (n) begin
         wdt_osc <= 1'b1;
         repeat (4) @(posedge clk);
         wdt_osc <= 1'b0;
         repeat (4) @(posedge clk);
      end
      #1; // let the design's flops settle before the caller looks at them
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_regs;
      rd(WDC_CTRL_OFFSET); check(got, WDC_CTRL_RESET, "control reset");
      wr(8'h07, 8'h0d); rd(8'h07); check(got, 8'h00, "unmapped read");
      rd(WDC_CTRL_OFFSET); check(got, 8'h00, "unmapped write leaked");
      wr(WDC_CTRL_OFFSET, 8'he5); rd(WDC_CTRL_OFFSET); check(got, 8'h05, "reserved bits");
      wr(WDC_CTRL_OFFSET, 8'h00);
      $display("test regs done");
   endtask
   task t_unlock;
      wr(WDC_CTRL_OFFSET, 8'h10); repeat (2) @(posedge clk);
      rd(WDC_CTRL_OFFSET); check(got, 8'h10, "unlock at fourth cycle");
      wr(WDC_CTRL_OFFSET, 8'h10); repeat (3) @(posedge clk);
      rd(WDC_CTRL_OFFSET); check(got, 8'h00, "unlock after four cycles");
      $display("test unlock done");
   endtask
   task t_guard;
      wr(WDC_CTRL_OFFSET, 8'h08); wr(WDC_CTRL_OFFSET, 8'h00);
      rd(WDC_CTRL_OFFSET); check(got, 8'h08, "cleared without unlock");
      wr(WDC_CTRL_OFFSET, 8'h18);
      rd(WDC_STAT_OFFSET); check(got, 8'h05, "status unlock open");
      repeat (6) @(posedge clk); wr(WDC_CTRL_OFFSET, 8'h00);
      rd(WDC_CTRL_OFFSET); check(got, 8'h08, "cleared after window");
      wr(WDC_CTRL_OFFSET, 8'h18); wr(WDC_CTRL_OFFSET, 8'h00);
      rd(WDC_CTRL_OFFSET); check(got, 8'h00, "turn-off sequence");
      osc(BASE + 3); check({7'h00, sys_reset_req}, 8'h00, "fired while off");
      rd(WDC_STAT_OFFSET); check(got, 8'h00, "status while off");
      $display("test guard done");
   endtask
   // expiry falls on the last of the selected count of edges after the refresh
   task t_period(input int sel);
      do_reset();
      refresh();
      wr(WDC_CTRL_OFFSET, 8'h08 | sel[7:0]);
      osc((BASE << sel) - 1); check({7'h00, sys_reset_req}, 8'h00, "early expiry");
      osc(1); check({7'h00, sys_reset_req}, 8'h01, "late expiry");
      rd(WDC_STAT_OFFSET); check(got, 8'h02, "status fired");
      $display("test period %0d done", sel);
   endtask
   task t_refresh;
      do_reset();
      wr(WDC_CTRL_OFFSET, 8'h08);
      osc(BASE - 1); refresh(); osc(BASE - 1);
      check({7'h00, sys_reset_req}, 8'h00, "refresh ignored");
      refresh(); wr(WDC_CTRL_OFFSET, 8'h09); osc(2 * BASE - 1);
      check({7'h00, sys_reset_req}, 8'h00, "period change");
      rd(WDC_STAT_OFFSET); check(got, 8'h01, "status running");
      osc(1); check({7'h00, sys_reset_req}, 8'h01, "no expiry after refresh");
      $display("test refresh done");
   endtask
   initial begin
      errors = 0; checked = 0; cycles = 0;
      rst_n = 1'b0; wdt_osc = 1'b0; refresh_instruction = 1'b0;
      req = '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_regs();
      t_unlock();
      t_guard();
      for (int s = 0; s < 8; s++) t_period(s);
      t_refresh();
      conclude();
   end
endmodule
`default_nettype wire
